//--- core/band_sched_pkg.sv
// constants, types and state layout shared by the band sampling scheduler
`default_nettype none
package band_sched_pkg;
  // ----------------------------------------
  // clock and band rates
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned NUM_BANDS = 4; // bit 0 is band 2 ... bit 3 is band 5
  localparam int unsigned B2_RATE_HZ = 24_000;
  localparam int unsigned B3_RATE_HZ = 2_400;
  localparam int unsigned B4_RATE_HZ = 150;
  localparam int unsigned B5_RATE_HZ = 15;
  localparam int unsigned B2_REC_MS = 100;
  localparam int unsigned B3_REC_MS = 1000;
  localparam int unsigned B4_REC_MS = 1000;
  localparam int unsigned B2_REC_SCANS = B2_RATE_HZ * B2_REC_MS / 1000;
  localparam int unsigned B3_REC_SCANS = B3_RATE_HZ * B3_REC_MS / 1000;
  localparam int unsigned B4_REC_SCANS = B4_RATE_HZ * B4_REC_MS / 1000;
  localparam int unsigned REBOOT_TIME_MS = 100;
  localparam int unsigned REBOOT_CYCLES = CLK_HZ / 1000 * REBOOT_TIME_MS;
  localparam int unsigned UPG_TIMER_W = 24;
  // ----------------------------------------
  // limits
  // ----------------------------------------
  localparam logic [11:0] SLOT_MAX_S = 12'he10; // 3600 s
  localparam logic [2:0] B2_MAX_REC = 3'h4;
  localparam logic [1:0] B3_MAX_REC = 2'h2;
  localparam logic [4:0] B4_MAX_REC = 5'h10;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SLOT_LEN_OFS = 8'h04;
  localparam logic [7:0] REC_CNT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] UPGRADE_OFS = 8'h10;
  localparam int unsigned CTRL_MODE_POS = 0;
  localparam int unsigned CTRL_RUN_POS = 2;
  localparam int unsigned CTRL_HI_OPEN_POS = 3;
  localparam int unsigned CNT_B2_POS = 0;
  localparam int unsigned CNT_B3_POS = 8;
  localparam int unsigned CNT_B4_POS = 16;
  localparam int unsigned ST_SLOT_POS = 0;
  localparam int unsigned ST_ODD_POS = 12;
  localparam int unsigned ST_REC_POS = 16;
  localparam int unsigned ST_UPG_POS = 20;
  localparam int unsigned ST_IND_POS = 22;
  localparam int unsigned UPG_GO_POS = 0;
  localparam logic [11:0] SLOT_LEN_RST = 12'h03c;
  localparam logic [2:0] B2_CNT_RST = 3'h4;
  localparam logic [1:0] B3_CNT_RST = 2'h2;
  localparam logic [4:0] B4_CNT_RST = 5'h08;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    audio_range_mode = 2'b00,
    long_period_mode = 2'b01,
    dense_audio_band_mode = 2'b10,
    audio_compatible_long_period_mode = 2'b11
  } data_type_t;
  typedef enum logic [1:0] {
    upg_idle = 2'b00,
    upg_boot1 = 2'b01,
    upg_boot2 = 2'b10,
    upg_done = 2'b11
  } upg_state_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    data_type_t mode;
    logic run;
    logic hi_open;
    logic [11:0] slot_len;
    logic [2:0] b2_cnt;
    logic [1:0] b3_cnt;
    logic [4:0] b4_cnt;
    logic [11:0] slot_idx;
    logic [11:0] sec_in_slot;
    logic [2:0] p2;
    logic [1:0] p3;
    logic [4:0] p4;
    logic rec_on;
    logic [1:0] rec_band;
    logic [11:0] scans_left;
    logic [NUM_BANDS-1:0] band_tick;
    upg_state_t upg;
    logic [UPG_TIMER_W-1:0] upg_timer;
    logic reboot;
    logic [31:0] rd_data;
  } sched_state_t;
endpackage
`default_nettype wire

//--- core/pin_edge_sync.sv
// two-flop synchroniser with rising-edge pulse for a pin
`default_nettype none
module pin_edge_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;
  sync_state_t q_ff;
  sync_state_t nxt_q;
  // ----------------------------------------
  // next state: meta feeds sync only
  // ----------------------------------------
  always_comb begin
    nxt_q.meta = pin_i;
    nxt_q.sync = q_ff.meta;
    nxt_q.last = q_ff.sync;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign rise_o = q_ff.sync & ~q_ff.last;
endmodule
`default_nettype wire

//--- core/rate_tick.sv
// fractional divider giving scan ticks at a band rate, realigned on restart
`default_nettype none
module rate_tick #(
  parameter int unsigned RATE_HZ = 150,
  parameter int unsigned CLK_HZ = 25_000_000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic restart_i,
  output logic tick_o
);
  localparam int unsigned ACC_W = $clog2(CLK_HZ + RATE_HZ + 1);
  localparam logic [ACC_W-1:0] STEP = ACC_W'(RATE_HZ);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_HZ);
  initial begin
    if (RATE_HZ == 0 || RATE_HZ > CLK_HZ / 2) begin
      $error("rate_tick: rate out of range");
    end
  end
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } tick_state_t;
  tick_state_t q_ff;
  tick_state_t nxt_q;
  // ----------------------------------------
  // accumulate; restart puts a tick on the boundary
  // ----------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.tick = 1'b0;
    if (restart_i) begin
      nxt_q.acc = '0;
      nxt_q.tick = 1'b1;
    end else if (q_ff.acc + STEP >= WRAP) begin
      nxt_q.acc = q_ff.acc + STEP - WRAP;
      nxt_q.tick = 1'b1;
    end else begin
      nxt_q.acc = q_ff.acc + STEP;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign tick_o = q_ff.tick;
endmodule
`default_nettype wire

//--- core/band_sampling_scheduler.sv
// acquisition scheduler: bands 2..5, utc slots, records, upgrade reboot sequence
//
// Implementation choices: the placing of the registers and the strobed register port.
`default_nettype none
module band_sampling_scheduler
  import band_sched_pkg::*;
#(
  parameter int unsigned REBOOT_CYC = REBOOT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic utc_second_i,
  input wire logic utc_hour_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [NUM_BANDS-1:0] band_tick_o,
  output logic [NUM_BANDS-1:0] record_active_o,
  output logic [11:0] slot_index_o,
  output logic slot_odd_o,
  output logic reboot_o,
  output logic indicator_o
);
  initial begin
    if (REBOOT_CYC < 1 || REBOOT_CYC >= (1 << UPG_TIMER_W)) begin
      $error("band_sampling_scheduler: reboot count does not fit");
    end
  end
  localparam logic [UPG_TIMER_W-1:0] REBOOT_LOAD = UPG_TIMER_W'(REBOOT_CYC - 1);
  localparam logic [11:0] B2_LEN = 12'(B2_REC_SCANS);
  localparam logic [11:0] B3_LEN = 12'(B3_REC_SCANS);
  localparam logic [11:0] B4_LEN = 12'(B4_REC_SCANS);

  // ----------------------------------------
  // utc pins and band rate generators
  // ----------------------------------------
  reg_req_t req;
  logic sec_p;
  logic hour_p;
  logic [NUM_BANDS-1:0] rate_hit;
  sched_state_t q_ff;
  sched_state_t nxt_q;

  assign req.addr = reg_addr_i;
  assign req.wdata = reg_wdata_i;
  assign req.wr = reg_wr_i;
  assign req.rd = reg_rd_i;

  pin_edge_sync u_sec_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(utc_second_i),
    .rise_o(sec_p)
  );
  pin_edge_sync u_hour_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(utc_hour_i),
    .rise_o(hour_p)
  );

  // one divider per band, realigned on every utc second
  localparam int unsigned BAND_RATE [NUM_BANDS] = '{B2_RATE_HZ, B3_RATE_HZ,
                                                    B4_RATE_HZ, B5_RATE_HZ};
  for (genvar g = 0; g < NUM_BANDS; g++) begin : g_rate
    rate_tick #(
      .RATE_HZ(BAND_RATE[g]),
      .CLK_HZ(CLK_HZ)
    ) u_rate (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .restart_i(sec_p),
      .tick_o(rate_hit[g])
    );
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic [NUM_BANDS-1:0] cont_mask;
  logic [NUM_BANDS-1:0] gate_mask;
  logic lp_mode;
  logic dense_mode;
  logic acm_mode;

  assign lp_mode = (q_ff.mode == long_period_mode);
  assign dense_mode = (q_ff.mode == dense_audio_band_mode);
  assign acm_mode = (q_ff.mode == audio_compatible_long_period_mode);

  // continuous bands per data type, bit 0 is band 2
  always_comb begin
    unique case (q_ff.mode)
      audio_range_mode: cont_mask = 4'h4;
      long_period_mode: cont_mask = 4'h8;
      dense_audio_band_mode: cont_mask = 4'h2;
      audio_compatible_long_period_mode: cont_mask = 4'h4;
    endcase
  end

  // bands closed while the high window is shut
  always_comb begin
    if (acm_mode) begin
      gate_mask = 4'h1;
    end else if (lp_mode) begin
      gate_mask = 4'h6;
    end else if (dense_mode) begin
      gate_mask = 4'h1;
    end else begin
      gate_mask = 4'h3;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic new_slot;
  logic slot_end;
  logic [11:0] next_idx;
  logic [2:0] p2;
  logic [1:0] p3;
  logic [4:0] p4;
  logic [NUM_BANDS-1:0] rec_vec;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.reboot = 1'b0;
    nxt_q.rd_data = '0;
    new_slot = 1'b0;
    next_idx = q_ff.slot_idx;
    slot_end = (q_ff.slot_len == 12'h000) ||
               (q_ff.sec_in_slot + 12'h001 >= q_ff.slot_len);

    // register writes
    if (req.wr) begin
      unique case (req.addr)
        CTRL_OFS: begin
          nxt_q.mode = data_type_t'(req.wdata[CTRL_MODE_POS +: 2]);
          nxt_q.run = req.wdata[CTRL_RUN_POS];
          nxt_q.hi_open = req.wdata[CTRL_HI_OPEN_POS];
        end
        SLOT_LEN_OFS: begin
          nxt_q.slot_len = (req.wdata[11:0] > SLOT_MAX_S) ? SLOT_MAX_S
                                                          : req.wdata[11:0];
        end
        REC_CNT_OFS: begin
          nxt_q.b2_cnt = (req.wdata[CNT_B2_POS +: 3] > B2_MAX_REC) ? B2_MAX_REC
                         : req.wdata[CNT_B2_POS +: 3];
          nxt_q.b3_cnt = (req.wdata[CNT_B3_POS +: 2] > B3_MAX_REC) ? B3_MAX_REC
                         : req.wdata[CNT_B3_POS +: 2];
          nxt_q.b4_cnt = (req.wdata[CNT_B4_POS +: 5] > B4_MAX_REC) ? B4_MAX_REC
                         : req.wdata[CNT_B4_POS +: 5];
        end
        UPGRADE_OFS: begin
          if (req.wdata[UPG_GO_POS]) begin
            nxt_q.upg = upg_boot1;
            nxt_q.upg_timer = REBOOT_LOAD;
            nxt_q.reboot = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // slot counting on utc seconds
    if (hour_p) begin
      next_idx = 12'h000;
      nxt_q.sec_in_slot = 12'h000;
      new_slot = 1'b1;
    end else if (sec_p) begin
      if (slot_end) begin
        next_idx = q_ff.slot_idx + 12'h001;
        nxt_q.sec_in_slot = 12'h000;
        new_slot = 1'b1;
      end else begin
        nxt_q.sec_in_slot = q_ff.sec_in_slot + 12'h001;
      end
    end
    nxt_q.slot_idx = next_idx;

    // pending records loaded at slot start by parity
    p2 = q_ff.p2;
    p3 = q_ff.p3;
    p4 = q_ff.p4;
    if (new_slot) begin
      if (!next_idx[0]) begin
        p2 = lp_mode ? 3'h0 : q_ff.b2_cnt;
        p3 = 2'h0;
        p4 = lp_mode ? q_ff.b4_cnt : 5'h00;
      end else begin
        p2 = 3'h0;
        p3 = dense_mode ? 2'h0 : q_ff.b3_cnt;
        p4 = 5'h00;
      end
    end

    // record progress on scans of the recording band
    if (q_ff.rec_on && rate_hit[q_ff.rec_band]) begin
      if (q_ff.scans_left == 12'h001) begin
        nxt_q.rec_on = 1'b0;
      end
      nxt_q.scans_left = q_ff.scans_left - 12'h001;
    end

    // start a record on a utc second
    if (sec_p && (!q_ff.rec_on || new_slot)) begin
      if (p2 != 3'h0) begin
        p2 = p2 - 3'h1;
        if (q_ff.hi_open || !gate_mask[0]) begin
          nxt_q.rec_on = 1'b1;
          nxt_q.rec_band = 2'd0;
          nxt_q.scans_left = B2_LEN;
        end
      end else if (p3 != 2'h0) begin
        p3 = p3 - 2'h1;
        if (q_ff.hi_open || !gate_mask[1]) begin
          nxt_q.rec_on = 1'b1;
          nxt_q.rec_band = 2'd1;
          nxt_q.scans_left = B3_LEN;
        end
      end else if (p4 != 5'h00) begin
        p4 = p4 - 5'h01;
        if (q_ff.hi_open || !gate_mask[2]) begin
          nxt_q.rec_on = 1'b1;
          nxt_q.rec_band = 2'd2;
          nxt_q.scans_left = B4_LEN;
        end
      end else begin
        nxt_q.rec_on = 1'b0;
      end
    end
    nxt_q.p2 = p2;
    nxt_q.p3 = p3;
    nxt_q.p4 = p4;

    // stopped scheduler drops the active record and all pending records
    if (!q_ff.run) begin
      nxt_q.rec_on = 1'b0;
      nxt_q.p2 = 3'h0;
      nxt_q.p3 = 2'h0;
      nxt_q.p4 = 5'h00;
    end

    // scan strobes: continuous bands plus the active record
    rec_vec = '0;
    if (q_ff.rec_on) begin
      rec_vec[q_ff.rec_band] = 1'b1;
    end
    nxt_q.band_tick = q_ff.run ? (rate_hit & (cont_mask | rec_vec)) : '0;

    // upgrade sequence: reboot, wait, reboot, wait, steady indicator
    unique case (q_ff.upg)
      upg_idle, upg_done: begin
      end
      upg_boot1: begin
        if (q_ff.upg_timer == '0) begin
          nxt_q.upg = upg_boot2;
          nxt_q.upg_timer = REBOOT_LOAD;
          nxt_q.reboot = 1'b1;
        end else begin
          nxt_q.upg_timer = q_ff.upg_timer - UPG_TIMER_W'(1);
        end
      end
      upg_boot2: begin
        if (q_ff.upg_timer == '0) begin
          nxt_q.upg = upg_done;
        end else begin
          nxt_q.upg_timer = q_ff.upg_timer - UPG_TIMER_W'(1);
        end
      end
    endcase
    if (req.wr && req.addr == UPGRADE_OFS && req.wdata[UPG_GO_POS]) begin
      nxt_q.upg = upg_boot1;
      nxt_q.upg_timer = REBOOT_LOAD;
      nxt_q.reboot = 1'b1;
    end

    // register reads, data in the following cycle
    if (req.rd) begin
      unique case (req.addr)
        CTRL_OFS: begin
          nxt_q.rd_data[CTRL_MODE_POS +: 2] = q_ff.mode;
          nxt_q.rd_data[CTRL_RUN_POS] = q_ff.run;
          nxt_q.rd_data[CTRL_HI_OPEN_POS] = q_ff.hi_open;
        end
        SLOT_LEN_OFS: nxt_q.rd_data[11:0] = q_ff.slot_len;
        REC_CNT_OFS: begin
          nxt_q.rd_data[CNT_B2_POS +: 3] = q_ff.b2_cnt;
          nxt_q.rd_data[CNT_B3_POS +: 2] = q_ff.b3_cnt;
          nxt_q.rd_data[CNT_B4_POS +: 5] = q_ff.b4_cnt;
        end
        STATUS_OFS: begin
          nxt_q.rd_data[ST_SLOT_POS +: 12] = q_ff.slot_idx;
          nxt_q.rd_data[ST_ODD_POS] = q_ff.slot_idx[0];
          nxt_q.rd_data[ST_REC_POS +: NUM_BANDS] = rec_vec;
          nxt_q.rd_data[ST_UPG_POS +: 2] = q_ff.upg;
          nxt_q.rd_data[ST_IND_POS] = (q_ff.upg == upg_done);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
      q_ff.mode <= audio_range_mode;
      q_ff.slot_len <= SLOT_LEN_RST;
      q_ff.b2_cnt <= B2_CNT_RST;
      q_ff.b3_cnt <= B3_CNT_RST;
      q_ff.b4_cnt <= B4_CNT_RST;
      q_ff.upg <= upg_idle;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_o = q_ff.rd_data;
  assign band_tick_o = q_ff.band_tick;
  assign slot_index_o = q_ff.slot_idx;
  assign slot_odd_o = q_ff.slot_idx[0];
  assign reboot_o = q_ff.reboot;
  assign indicator_o = (q_ff.upg == upg_done);
  assign record_active_o = q_ff.rec_on ? (4'h1 << q_ff.rec_band) : 4'h0;
endmodule
`default_nettype wire

//--- test/band_sched_sva.sv
// port-level assertion checker for the band sampling scheduler
`default_nettype none
module band_sched_sva
  import band_sched_pkg::*;
#(
  parameter int unsigned REBOOT_CYC = REBOOT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic utc_second_i,
  input wire logic utc_hour_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [NUM_BANDS-1:0] band_tick_o,
  input wire logic [NUM_BANDS-1:0] record_active_o,
  input wire logic [11:0] slot_index_o,
  input wire logic slot_odd_o,
  input wire logic reboot_o,
  input wire logic indicator_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [1:0] mode_ff;
  logic [1:0] mode_d_ff;
  logic [1:0] boots_ff;
  logic upg_wr;
  logic same;
  assign upg_wr = reg_wr_i && reg_addr_i == UPGRADE_OFS && reg_wdata_i[UPG_GO_POS];
  assign same = mode_ff == mode_d_ff;
  // mirror data type, count reboots since the last upgrade request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= 2'h0;
      mode_d_ff <= 2'h0;
      boots_ff <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == CTRL_OFS) begin
        mode_ff <= reg_wdata_i[CTRL_MODE_POS +: 2];
      end
      mode_d_ff <= mode_ff;
      if (upg_wr) begin
        boots_ff <= 2'h0;
      end else if (reboot_o && boots_ff != 2'h3) begin
        boots_ff <= boots_ff + 2'h1;
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_parity_bit: assert property (slot_odd_o == slot_index_o[0])
    else $error("slot parity differs from slot index");
  chk_one_record: assert property ($onehot0(record_active_o))
    else $error("more than one periodic record at once");
  chk_hour_restart: assert property ($rose(utc_hour_i) |-> ##[2:10] slot_index_o == 12'h000)
    else $error("hour marker did not restart slot index");
  chk_slot_bound: assert property (slot_index_o <= 12'he0f)
    else $error("slot index beyond one hour");
  chk_long_no_b2: assert property (same && mode_ff == long_period_mode |->
    band_tick_o[0] == 1'b0 && record_active_o[0] == 1'b0)
    else $error("band 2 activity in long-period mode");
  chk_dense_no_b4: assert property (same && mode_ff == dense_audio_band_mode |->
    band_tick_o[2] == 1'b0 && record_active_o[2:1] == 2'h0)
    else $error("band 3 record or band 4 activity in dense mode");
  chk_b4_cont: assert property (same && mode_ff[0] == mode_ff[1] |-> !record_active_o[2])
    else $error("band 4 record where band 4 runs continuously");
  chk_b5_long_only: assert property (same && mode_ff != long_period_mode |-> !band_tick_o[3])
    else $error("band 5 tick outside long-period mode");
  chk_upg_reboot: assert property (upg_wr |=> reboot_o)
    else $error("upgrade request gave no reboot");
  chk_two_reboots: assert property ($rose(indicator_o) |-> boots_ff == 2'h2)
    else $error("indicator lit without two reboots");
  chk_ind_steady: assert property (indicator_o && !upg_wr |=> indicator_o)
    else $error("indicator dropped after upgrade");
  cover property ($rose(record_active_o[0]));
  cover property ($rose(record_active_o[1]));
  cover property ($rose(indicator_o));
endmodule
`default_nettype wire

//--- test/utc_ref_model.sv
// utc time reference model: second and hour marker pins
`default_nettype none
module utc_ref_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sec_go_i,
  input wire logic hour_go_i,
  output logic utc_second_o,
  output logic utc_hour_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_ff;
  logic hour_ff;
  // marker rises on request, falls after a short hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_ff <= 4'h0;
      hour_ff <= 1'b0;
    end else if (sec_go_i || hour_go_i) begin
      hold_ff <= 4'h8;
      hour_ff <= hour_go_i;
    end else if (hold_ff != 4'h0) begin
      hold_ff <= hold_ff - 4'h1;
    end
  end
  // an hour start is also a second boundary
  assign utc_second_o = hold_ff != 4'h0;
  assign utc_hour_o = utc_second_o && hour_ff;
endmodule
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the band sampling scheduler
`default_nettype none
module tb_top
  import band_sched_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RB = 20;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sec_go = 1'b0;
  logic hour_go = 1'b0;
  logic sec_pin;
  logic hour_pin;
  logic reboot;
  logic ind;
  logic odd;
  logic [31:0] rdata;
  logic [3:0] tick;
  logic [3:0] rec;
  logic [11:0] slot;
  int fail_count = 0;
  int check_count = 0;
  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  band_sampling_scheduler #(.REBOOT_CYC(RB)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .utc_second_i(sec_pin), .utc_hour_i(hour_pin), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .band_tick_o(tick),
    .record_active_o(rec), .slot_index_o(slot), .slot_odd_o(odd), .reboot_o(reboot),
    .indicator_o(ind));
  utc_ref_model utc (.clk_i(clk_i), .rst_n_i(rst_n_i), .sec_go_i(sec_go),
    .hour_go_i(hour_go), .utc_second_o(sec_pin), .utc_hour_o(hour_pin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    check(what, exp, rdata);
  endtask
  task automatic setup(input logic [1:0] m, input logic hi, input logic [11:0] len);
    do_reset();
    wr_reg(SLOT_LEN_OFS, {20'h0, len});
    wr_reg(CTRL_OFS, {28'h0, hi, 1'b1, m});
  endtask
  task automatic utc_pulse(input logic hour);
    @(posedge clk_i);
    sec_go <= 1'b1;
    hour_go <= hour;
    @(posedge clk_i);
    sec_go <= 1'b0;
    hour_go <= 1'b0;
  endtask
  task automatic wait_tick(input int b, input int limit, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (tick[b] !== 1'b1 && n < limit);
    if (tick[b] !== 1'b1) begin
      check("tick wait", 32'h1, 32'h0);
      wrap_up();
    end
  endtask
  task automatic tick_gap(input int b, input int lo, input int hi, input string what);
    int n;
    wait_tick(b, hi + 50, n);
    wait_tick(b, hi + 5, n);
    check(what, 32'h1, {31'h0, n >= lo && n <= hi});
  endtask
  task automatic no_ticks(input int b, input string what);
    int c;
    c = 0;
    repeat (3000) begin
      @(posedge clk_i);
      #1;
      if (tick[b] !== 1'b0) c++;
    end
    check(what, 32'h0, c);
  endtask
  task automatic expect_rec(input logic [3:0] exp, input string what);
    repeat (30) @(posedge clk_i);
    #1;
    check(what, {28'h0, exp}, {28'h0, rec});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_regs();
    do_reset();
    chk_reg(CTRL_OFS, 32'h0, "ctrl reset");
    chk_reg(SLOT_LEN_OFS, {20'h0, SLOT_LEN_RST}, "slot len reset");
    chk_reg(REC_CNT_OFS, {11'h0, B4_CNT_RST, 6'h0, B3_CNT_RST, 5'h0, B2_CNT_RST}, "cnt reset");
    wr_reg(SLOT_LEN_OFS, 32'h00000fff);
    chk_reg(SLOT_LEN_OFS, {20'h0, SLOT_MAX_S}, "slot len clamp");
    wr_reg(REC_CNT_OFS, 32'h001f0307);
    chk_reg(REC_CNT_OFS, {11'h0, B4_MAX_REC, 6'h0, B3_MAX_REC, 5'h0, B2_MAX_REC}, "cnt");
    wr_reg(STATUS_OFS, 32'hffffffff);
    chk_reg(STATUS_OFS, 32'h0, "status read only");
    wr_reg(8'h20, 32'hffffffff);
    chk_reg(8'h20, 32'h0, "unmapped");
  endtask
  task automatic sc_audio();
    int n;
    setup(2'h0, 1'b1, 12'h001);
    utc_pulse(1'b1);
    wait_tick(2, 50, n);
    expect_rec(4'h1, "audio slot 0 record");
    check("slot after hour", 32'h0, {20'h0, slot});
    tick_gap(0, 1041, 1042, "band 2 gap");
    utc_pulse(1'b0);
    expect_rec(4'h2, "odd slot band 3 record");
    check("odd slot", 32'h1, {31'h0, odd});
    utc_pulse(1'b1);
    expect_rec(4'h1, "record after hour");
    check("slot restart", 32'h0, {20'h0, slot});
  endtask
  task automatic sc_long();
    int n;
    setup(2'h1, 1'b1, 12'h001);
    utc_pulse(1'b1);
    wait_tick(3, 50, n);
    expect_rec(4'h4, "long slot 0 record");
    no_ticks(0, "band 2 in long");
  endtask
  task automatic sc_dense();
    setup(2'h2, 1'b1, 12'h001);
    utc_pulse(1'b1);
    expect_rec(4'h1, "dense band 2 record");
    no_ticks(2, "band 4 in dense");
    tick_gap(1, 10416, 10417, "band 3 gap");
  endtask
  task automatic sc_compat();
    setup(2'h3, 1'b0, 12'h000);
    utc_pulse(1'b1);
    expect_rec(4'h0, "gated band 2");
    utc_pulse(1'b0);
    expect_rec(4'h2, "ungated band 3");
    check("odd slot", 32'h1, {31'h0, odd});
    chk_reg(STATUS_OFS, 32'h00021001, "status odd slot");
  endtask
  task automatic sc_upgrade();
    int boots;
    boots = 0;
    do_reset();
    wr_reg(UPGRADE_OFS, 32'h1);
    repeat (4 * RB + 40) begin
      #1;
      if (reboot === 1'b1) boots++;
      if (ind === 1'b1) break;
      @(posedge clk_i);
    end
    check("reboots", 32'h2, boots);
    repeat (50) @(posedge clk_i);
    #1;
    check("indicator steady", 32'h1, {31'h0, ind});
  endtask
  // main sequence
  initial begin
    sc_regs();
    sc_audio();
    sc_long();
    sc_dense();
    sc_compat();
    sc_upgrade();
    wrap_up();
  end
endmodule
bind band_sampling_scheduler band_sched_sva #(.REBOOT_CYC(REBOOT_CYC)) sva (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .utc_second_i(utc_second_i), .utc_hour_i(utc_hour_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .band_tick_o(band_tick_o),
  .record_active_o(record_active_o), .slot_index_o(slot_index_o), .slot_odd_o(slot_odd_o),
  .reboot_o(reboot_o), .indicator_o(indicator_o));
`default_nettype wire
